// ---- core/qvt_elapsed.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------------
// Saturating elapsed-cycle counter, held at zero while cleared.
// ----------------------------------------------------------------------------
module qvt_elapsed
	import qvt_pkg::*;
#(
	parameter int W = CNT_W
)
(
	input  wire logic         core_clk_in,
	input  wire logic         rst_in,
	input  wire logic         clr_in,
	output logic [W-1:0]      cnt_out
);

	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;

	generate
		if (W < 2)
		begin : g_chk
			$error("qvt_elapsed: width too small");
		end
	endgenerate

	// Saturation keeps a very long off time from wrapping into a false short one.
	always_comb
	begin
		cnt_next = cnt_reg;
		if (clr_in)
			cnt_next = '0;
		else if (cnt_reg != {W{1'b1}})
			cnt_next = cnt_reg + {{(W-1){1'b0}}, 1'b1};
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_next;
	end

	assign cnt_out = cnt_reg;

endmodule
`default_nettype wire

// ---- core/qvt_pkg.sv ----
// ----------------------------------------------------------------------------
// Timing constants and state codes for the valley turn-on control.
// ----------------------------------------------------------------------------
package qvt_pkg;

	localparam int CLK_KHZ       = 20000;
	localparam int OSC_LIM_L_KHZ = 136;
	localparam int OSC_LIM_H_KHZ = 225;
	// Least periods: round up so switching never exceeds the frequency limit.
	localparam int OSC_L_CYC     = (CLK_KHZ + OSC_LIM_L_KHZ - 1) / OSC_LIM_L_KHZ;
	localparam int OSC_H_CYC     = (CLK_KHZ + OSC_LIM_H_KHZ - 1) / OSC_LIM_H_KHZ;
	localparam int FLOOR_DIV     = 64;
	localparam int FLOOR_L_CYC   = OSC_L_CYC * FLOOR_DIV;
	localparam int FLOOR_H_CYC   = OSC_H_CYC * FLOOR_DIV;
	localparam int STARTER_DIV   = 4;
	localparam int BLANK_SHORT_US  = 2500;
	localparam int BLANK_LONG_US   = 6300;
	localparam int BLANK_SHORT_CYC = (BLANK_SHORT_US * CLK_KHZ + 999) / 1000;
	localparam int BLANK_LONG_CYC  = (BLANK_LONG_US * CLK_KHZ + 999) / 1000;
	localparam int STROBE_NS     = 2000;
	localparam int STROBE_CYC    = (STROBE_NS * CLK_KHZ + 999999) / 1000000;
	localparam int TON_DELAY_NS  = 200;
	localparam int TON_CYC_RAW   = (TON_DELAY_NS * CLK_KHZ + 999999) / 1000000;
	localparam int TON_CYC       = (TON_CYC_RAW < 1) ? 1 : TON_CYC_RAW;
	localparam int CNT_W         = 18;
	localparam int DLY_W         = 4;

	typedef enum logic [2:0]
	{
		ST_OFF   = 3'b001,
		ST_DELAY = 3'b010,
		ST_ON    = 3'b100
	} qvt_state_t;

endpackage

// ---- core/qvt_valley_ctrl.sv ----
// Overview of operation
// - Fire edge counts only after prior arming
// - Gate turns on after fixed delay
// - Ignore sense edges during post-off mask
// - Limit oscillator 136/225 kHz, restarted at turn-on
// - Armed fire after full period turns on
// - Early fire discarded, re-arm, skip valley
// - Need both mask and period expired
// - Mask lasts 2.5 ms or 6.3 ms
// - Sample below 1 V short, above long
// - Never armed: switch at starter rate
// - Arming returns control to valley switching
// - Arm level stuck high: floor frequency
// - Sample taken fixed strobe delay after off
`timescale 1ns/1ns
`default_nettype none
module qvt_valley_ctrl
	import qvt_pkg::*;
#(
	parameter int BLANK_SHORT_P = BLANK_SHORT_CYC,
	parameter int BLANK_LONG_P  = BLANK_LONG_CYC,
	parameter int FLOOR_L_P     = FLOOR_L_CYC,
	parameter int FLOOR_H_P     = FLOOR_H_CYC
)
(
	input  wire logic core_clk_in,
	input  wire logic rst_in,
	input  wire logic arm_cmp_in,
	input  wire logic fire_cmp_in,
	input  wire logic strobe_cmp_in,
	input  wire logic high_variant_in,
	input  wire logic turn_off_in,
	output logic      gate_on_out,
	output logic      starter_mode_out,
	output logic      long_blank_out
);

	// ------------------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------------------
	generate
		if (BLANK_SHORT_P <= STROBE_CYC || BLANK_LONG_P <= STROBE_CYC ||
			BLANK_LONG_P >= (1 << CNT_W) - 1 || FLOOR_L_P >= (1 << CNT_W) - 1 ||
			FLOOR_H_P >= (1 << CNT_W) - 1 || TON_CYC >= (1 << DLY_W))
		begin : g_chk
			$error("qvt_valley_ctrl: count parameters out of range");
		end
	endgenerate

	localparam int A_TON = TON_CYC;

	// ------------------------------------------------------------------------
	// State and counters
	// ------------------------------------------------------------------------
	qvt_state_t       st_reg;
	qvt_state_t       st_next;
	logic             arm_prev_reg;
	logic             fire_prev_reg;
	logic             armed_reg;
	logic             armed_next;
	logic             seen_arm_reg;
	logic             seen_arm_next;
	logic             arm_high_all_reg;
	logic             arm_high_all_next;
	logic             long_sel_reg;
	logic             long_sel_next;
	logic             starter_reg;
	logic             starter_next;
	logic             gate_reg;
	logic             gate_next;
	logic [DLY_W-1:0] dly_reg;
	logic [DLY_W-1:0] dly_next;
	logic [CNT_W-1:0] osc_cnt;
	logic [CNT_W-1:0] off_cnt;
	logic             osc_clr;
	logic             off_clr;

	logic             in_off;
	logic [CNT_W-1:0] osc_per;
	logic [CNT_W-1:0] floor_per;
	logic [CNT_W-1:0] starter_per;
	logic [CNT_W-1:0] blank_len;
	logic             osc_done;
	logic             blank_done;
	logic             strobe_hit;
	logic             arm_rise;
	logic             fire_fall;
	logic             fire_evt;
	logic             accept;
	logic             starter_go;
	logic             floor_go;
	logic             go;
	logic             dly_end;

	assign osc_clr = (st_reg == ST_DELAY) && dly_end;
	assign off_clr = !in_off;

	qvt_elapsed #(
		.W (CNT_W)
	) u_osc (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.clr_in      (osc_clr),
		.cnt_out     (osc_cnt)
	);

	qvt_elapsed #(
		.W (CNT_W)
	) u_off (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.clr_in      (off_clr),
		.cnt_out     (off_cnt)
	);

	// ------------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------------
	assign in_off = (st_reg == ST_OFF);
	assign osc_per     = high_variant_in ? CNT_W'(OSC_H_CYC) : CNT_W'(OSC_L_CYC);
	assign floor_per   = high_variant_in ? CNT_W'(FLOOR_H_P) : CNT_W'(FLOOR_L_P);
	assign starter_per = CNT_W'(osc_per * CNT_W'(STARTER_DIV));
	assign osc_done    = osc_cnt >= osc_per;
	assign blank_len   = long_sel_reg ? CNT_W'(BLANK_LONG_P) : CNT_W'(BLANK_SHORT_P);
	assign blank_done  = (off_cnt > CNT_W'(STROBE_CYC)) && (off_cnt >= blank_len);
	assign strobe_hit  = in_off && (off_cnt == CNT_W'(STROBE_CYC));
	assign arm_rise    = arm_cmp_in && !arm_prev_reg;
	assign fire_fall   = fire_prev_reg && !fire_cmp_in;
	assign fire_evt    = in_off && blank_done && armed_reg && fire_fall;
	assign accept      = fire_evt && osc_done;
	assign starter_go  = in_off && blank_done && !seen_arm_reg && !arm_high_all_reg &&
		(osc_cnt >= starter_per);
	// stuck arm level uses floor rate
	assign floor_go    = in_off && blank_done && arm_high_all_reg && (osc_cnt >= floor_per);
	// mask and period both gate turn-on
	assign go          = accept || starter_go || floor_go;
	assign dly_end     = dly_reg == DLY_W'(TON_CYC - 1);

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb
	begin
		st_next           = st_reg;
		armed_next        = armed_reg;
		seen_arm_next     = seen_arm_reg;
		arm_high_all_next = arm_high_all_reg;
		long_sel_next     = long_sel_reg;
		starter_next      = starter_reg;
		gate_next         = gate_reg;
		dly_next          = dly_reg;
		unique case (st_reg)
			ST_OFF:
			begin
				if (!arm_cmp_in)
					arm_high_all_next = 1'b0;
				if (strobe_hit)
					long_sel_next = strobe_cmp_in;
				if (fire_evt)
					armed_next = 1'b0;
				else if (arm_rise && blank_done)
				begin
					armed_next    = 1'b1;
					seen_arm_next = 1'b1;
				end
				if (accept)
					starter_next = 1'b0;
				else if (starter_go)
					starter_next = 1'b1;
				if (go)
				begin
					st_next  = ST_DELAY;
					dly_next = '0;
				end
			end
			ST_DELAY:
			begin
				armed_next = 1'b0;
				if (dly_end)
				begin
					st_next   = ST_ON;
					gate_next = 1'b1;
				end
				else
					dly_next = dly_reg + DLY_W'(1);
			end
			ST_ON:
			begin
				armed_next = 1'b0;
				if (turn_off_in)
				begin
					st_next           = ST_OFF;
					gate_next         = 1'b0;
					seen_arm_next     = 1'b0;
					arm_high_all_next = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			st_reg           <= ST_OFF;
			arm_prev_reg     <= 1'b0;
			fire_prev_reg    <= 1'b0;
			armed_reg        <= 1'b0;
			seen_arm_reg     <= 1'b0;
			arm_high_all_reg <= 1'b0;
			long_sel_reg     <= 1'b1;
			starter_reg      <= 1'b0;
			gate_reg         <= 1'b0;
			dly_reg          <= '0;
		end
		else
		begin
			st_reg           <= st_next;
			arm_prev_reg     <= arm_cmp_in;
			fire_prev_reg    <= fire_cmp_in;
			armed_reg        <= armed_next;
			seen_arm_reg     <= seen_arm_next;
			arm_high_all_reg <= arm_high_all_next;
			long_sel_reg     <= long_sel_next;
			starter_reg      <= starter_next;
			gate_reg         <= gate_next;
			dly_reg          <= dly_next;
		end
	end

	assign gate_on_out      = gate_reg;
	assign starter_mode_out = starter_reg;
	assign long_blank_out   = long_sel_reg;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);

	sequence seq_accept;
		in_off && armed_reg && fire_fall && blank_done && osc_done;
	endsequence

	sequence seq_turn_on;
		(st_reg == ST_DELAY) ##A_TON gate_on_out;
	endsequence

	a_fire_needs_arm: assert property (fire_evt |-> $past(armed_next) && armed_reg)
		else $error("fire accepted without arming");
	a_delay_then_on: assert property (seq_accept |=> seq_turn_on)
		else $error("turn-on delay wrong");
	a_mask_blocks_go: assert property (in_off && !blank_done |=> st_reg == ST_OFF)
		else $error("turn-on inside mask");
	a_osc_restart: assert property ($rose(gate_on_out) |-> osc_cnt == '0)
		else $error("oscillator not restarted at turn-on");
	a_period_gates_fire: assert property ($rose(st_reg == ST_DELAY) && !osc_done |->
		$past(starter_go) || $past(floor_go) || $past(osc_done))
		else $error("turn-on before period");
	a_early_discard: assert property (fire_evt && !osc_done && !starter_go && !floor_go
		|=> !armed_reg && st_reg == ST_OFF)
		else $error("early fire not discarded");
	a_long_select: assert property (strobe_hit |=> long_sel_reg == $past(strobe_cmp_in))
		else $error("mask length not from sample");
	a_starter_flag: assert property (starter_go && !accept |=> starter_mode_out ##A_TON gate_on_out)
		else $error("starter turn-on missing");
	a_floor_rate: assert property (floor_go |-> osc_cnt >= floor_per && arm_high_all_reg)
		else $error("floor turn-on too early");

endmodule
`default_nettype wire

// ---- test/qr_valley_turn_on_control_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
`define check_eq(nm, e, g) begin compares++; if ((e) !== (g)) begin errors++; \
	$display("unexpected %s expected %0d seen %0d", nm, e, g); end end
module qr_valley_turn_on_control_bench;
	import qvt_pkg::*;
	logic       core_clk = 1'b0;
	logic       rst = 1'b1;
	logic       hv = 1'b0;
	logic [1:0] mode = 2'd0;
	logic       strb = 1'b0;
	logic       arm;
	logic       fire;
	logic       sdig;
	logic       toff;
	logic       gate;
	logic       starter;
	logic       longb;
	logic       fire_d = 1'b0;
	int         cyc = 0;
	int         fall_cyc = 0;
	int         errors = 0;
	int         compares = 0;
	// ------------------------------------------------------------------------
	// Clock, cycle count and watchdog.
	// ------------------------------------------------------------------------
	initial
	begin
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		fire_d <= fire;
		if (fire_d && !fire)
			fall_cyc <= cyc;
		if (cyc == 20000)
		begin
			errors++;
			final_report();
		end
	end
	qvt_valley_ctrl #(.BLANK_SHORT_P(60), .BLANK_LONG_P(200), .FLOOR_L_P(1200), .FLOOR_H_P(800))
	qvt_valley_ctrl_i (.core_clk_in(core_clk), .rst_in(rst), .arm_cmp_in(arm), .fire_cmp_in(fire),
		.strobe_cmp_in(sdig), .high_variant_in(hv), .turn_off_in(toff), .gate_on_out(gate),
		.starter_mode_out(starter), .long_blank_out(longb));
	qvt_partner qvt_partner_i (.core_clk_in(core_clk), .gate_in(gate), .mode_in(mode),
		.strobe_in(strb), .arm_out(arm), .fire_out(fire), .strobe_out(sdig), .off_out(toff));
	// ------------------------------------------------------------------------
	// Shared tasks.
	// ------------------------------------------------------------------------
	function automatic logic in_rng(input int v, input int lo, input int hi);
		return (v >= lo) && (v <= hi);
	endfunction
	task automatic start(input logic [1:0] m, input logic s, input logic h);
		rst <= 1'b1;
		mode <= m;
		strb <= s;
		hv <= h;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
	endtask
	task automatic wait_gate(input logic lvl, output int t);
		for (int i = 0; i < 4000 && gate === lvl; i++) @(posedge core_clk);
		for (int i = 0; i < 4000 && gate !== lvl; i++) @(posedge core_clk);
		t = cyc;
	endtask
	task automatic final_report();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ------------------------------------------------------------------------
	// Scenarios.
	// ------------------------------------------------------------------------
	task automatic t_starter();
		int r1, r2;
		start(2'd2, 1'b0, 1'b0);
		`check_eq("reset gate", 1'b0, gate)
		`check_eq("reset mask long", 1'b1, longb)
		repeat (2) wait_gate(1'b1, r1);
		wait_gate(1'b1, r2);
		`check_eq("starter gap", 1'b1, in_rng(r2 - r1, STARTER_DIV * OSC_L_CYC, 600))
		repeat (3) @(posedge core_clk);
		`check_eq("starter flag", 1'b1, starter)
		`check_eq("short select", 1'b0, longb)
	endtask
	task automatic t_valley();
		int r1, r2, f;
		start(2'd1, 1'b0, 1'b0);
		repeat (3) wait_gate(1'b1, r1);
		wait_gate(1'b0, f);
		wait_gate(1'b1, r2);
		`check_eq("valley gap", 1'b1, in_rng(r2 - r1, OSC_L_CYC, OSC_L_CYC + 40))
		`check_eq("turn-on delay", 1'b1, in_rng(r2 - fall_cyc, TON_CYC + 1, TON_CYC + 2))
		`check_eq("short mask off", 1'b1, in_rng(r2 - f, 60, 199))
		`check_eq("starter left", 1'b0, starter)
	endtask
	task automatic t_high();
		int r1, r2;
		start(2'd1, 1'b0, 1'b1);
		repeat (3) wait_gate(1'b1, r1);
		wait_gate(1'b1, r2);
		`check_eq("high gap", 1'b1, in_rng(r2 - r1, OSC_H_CYC, OSC_H_CYC + 40))
	endtask
	task automatic t_long();
		int r, f;
		start(2'd1, 1'b1, 1'b0);
		repeat (3) wait_gate(1'b1, r);
		wait_gate(1'b0, f);
		wait_gate(1'b1, r);
		`check_eq("long mask off", 1'b1, in_rng(r - f, 200, 240))
		`check_eq("long select", 1'b1, longb)
	endtask
	task automatic t_floor();
		int r1, r2;
		start(2'd3, 1'b0, 1'b0);
		repeat (2) wait_gate(1'b1, r1);
		wait_gate(1'b1, r2);
		`check_eq("floor gap", 1'b1, in_rng(r2 - r1, 1200, 1210))
	endtask
	initial
	begin
		t_starter();
		t_valley();
		t_high();
		t_long();
		t_floor();
		final_report();
	end
endmodule
`default_nettype wire

// ---- test/qvt_partner.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------------
// Sense comparators and gate driver model.
// ----------------------------------------------------------------------------
module qvt_partner
(
	input  wire logic       core_clk_in,
	input  wire logic       gate_in,
	input  wire logic [1:0] mode_in,
	input  wire logic       strobe_in,
	output logic            arm_out = 1'b0,
	output logic            fire_out = 1'b0,
	output logic            strobe_out = 1'b0,
	output logic            off_out = 1'b0
);
	logic [7:0] t_reg = 8'h00;
	logic       g_reg = 1'b0;
	logic       ring;
	// Ringing of 32 cycles starts afresh at each gate edge, so every
	// off time sees the same valley pattern.
	assign ring = !gate_in && t_reg[4];
	always_ff @(posedge core_clk_in)
	begin
		g_reg <= gate_in;
		t_reg <= (gate_in != g_reg) ? 8'h00 : t_reg + 8'h01;
		off_out <= gate_in && (t_reg >= 8'h09);
		arm_out <= (mode_in == 2'd3) || ((mode_in == 2'd1) && ring);
		fire_out <= (mode_in == 2'd3) || ((mode_in != 2'd0) && ring);
		strobe_out <= strobe_in;
	end
endmodule
`default_nettype wire
